// >>> include/laa_pkg.sv
package laa_pkg;
  localparam int NUM_LOC = 5;
  localparam int LOC_W = 3;
  // bit positions of the locality ownership register
  localparam int BIT_VALID = 7;
  localparam int BIT_OWNS = 5;
  localparam int BIT_LOST = 4;
  localparam int BIT_PREEMPT = 3;
  localparam int BIT_OTHER = 2;
  localparam int BIT_REQ = 1;
  localparam int BIT_EST = 0;
  localparam logic [2:0] LOC_NONE = 3'h7;
  // first timeout interval, in ns, and its cycle count at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int TIMEOUT_A_NS = 750000;
  localparam int TIMEOUT_A_CYC = TIMEOUT_A_NS / CLK_PERIOD_NS;
  // cycles the nonvolatile copy needs before it is known good
  localparam int NV_LOAD_CYC = 16;
  localparam int NV_CNT_W = 5;
  typedef enum logic [2:0] {
    NV_LOAD = 3'h1,
    NV_IDLE = 3'h2,
    NV_WRITE = 3'h4
  } laa_nv_state_type;
endpackage

// >>> include/laa_nv_if.sv
`timescale 1ns/10ps
interface laa_nv_if;
  logic clear_req;
  logic set_req;
  logic busy;
  logic known;
  logic value;
  modport ctrl(output clear_req, output set_req, input busy, input known, input value);
  modport store(input clear_req, input set_req, output busy, output known, output value);
endinterface

// >>> rtl/laa_nv_bit.sv
`timescale 1ns/10ps
module laa_nv_bit #(
  parameter int LOAD_CYC = laa_pkg::NV_LOAD_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic nv_in,
  laa_nv_if.store nv
);
  typedef struct packed {
    laa_pkg::laa_nv_state_type st;
    logic [laa_pkg::NV_CNT_W-1:0] cnt;
    logic value;
    logic known;
    logic pend;
    logic hold;
  } laa_nv_st_type;
  laa_nv_st_type s_reg;
  laa_nv_st_type s_next;
  // models the nonvolatile cell: value loads from nv_in after reset, writes take one wait
  always_comb begin
    s_next = s_reg;
    case (s_reg.st)
      laa_pkg::NV_LOAD: begin
        // an update seen during the load outranks the old stored value
        if (nv.clear_req || nv.set_req) begin
          s_next.pend = !nv.clear_req;
          s_next.hold = 1'b1;
        end
        if (s_reg.cnt == laa_pkg::NV_CNT_W'(LOAD_CYC - 1)) begin
          s_next.value = s_next.hold ? s_next.pend : nv_in;
          s_next.known = 1'b1;
          s_next.st = laa_pkg::NV_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt + 1'b1;
        end
      end
      laa_pkg::NV_IDLE: begin
        if (nv.clear_req || nv.set_req) begin
          // clear wins: a fresh hash sequence must never be hidden
          s_next.pend = !nv.clear_req;
          s_next.st = laa_pkg::NV_WRITE;
        end
      end
      laa_pkg::NV_WRITE: begin
        s_next.value = s_reg.pend;
        // a request during the write is kept, never dropped
        if (nv.clear_req || nv.set_req) begin
          s_next.pend = !nv.clear_req;
        end else begin
          s_next.st = laa_pkg::NV_IDLE;
        end
      end
      default: s_next.st = laa_pkg::NV_LOAD;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{st: laa_pkg::NV_LOAD, cnt: '0, value: 1'b0, known: 1'b0, pend: 1'b0, hold: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign nv.busy = (s_reg.st != laa_pkg::NV_IDLE);
  assign nv.known = s_reg.known;
  assign nv.value = s_reg.value;
endmodule

// >>> rtl/laa_arbiter.sv
`timescale 1ns/10ps
// How it works
// - owns bit reads one for the owner; writing one relinquishes and drops the request
// - on release the highest-numbered requesting locality is granted
// - with no owner a request is granted well inside the first timeout
// - a locality preempted while owning gets its lost-ownership flag set
// - lost flag clears on written one; zero leaves it alone
// - preempt bit is write-only and reads zero
// - preempt from a locality not above the owner is ignored
// - successful preempt strips the lower owner and stops its commands
// - preemptor becomes owner, its request drops, others keep theirs
// - preempt through locality zero is ignored
// - with preempt set, bits 5 and 1 of that write are ignored
// - bit 4 together with preempt clears lost flag and preempts
// - preempt may abort a running command; software must not rely on it
// - other-request bit reads one while any other locality requests
// - request bit reads one while pending and clears on grant
// - writing the request bit never clears it
// - established-low bit clears on hash sequence begin, reads one before
// - established-low bit lives in nonvolatile storage across resets; here it reloads from NV_STORED after reset and no port writes it back
// - restore-establishment command sets established-low bit back to one
// - accept-command is held off until the established-low bit is updated
// - valid bit waits for a known established-low value
// - non-preempt writes with more than one bit set are discarded
// - valid bit stays zero until self test and initialization finish
// - a request with no owner grants at once, else stays pending
module laa_arbiter #(
  parameter int NUM_LOC = laa_pkg::NUM_LOC,
  parameter int TIMEOUT_A_CYC = laa_pkg::TIMEOUT_A_CYC
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [2:0] LOCALITY,
  input wire logic [7:0] WR_DATA,
  input wire logic HASH_BEGIN,
  input wire logic RESTORE_EST,
  input wire logic INIT_DONE,
  input wire logic NV_STORED,
  input wire logic CMD_READY_REQ,
  output logic [7:0] RD_DATA,
  output logic [2:0] OWNER,
  output logic OWNER_VALID,
  output logic ACCEPT_COMMAND_OK,
  output logic ABORT,
  output logic [NUM_LOC-1:0] LOC_CMD_ENABLE
);
  typedef struct packed {
    logic [NUM_LOC-1:0] req;
    logic [NUM_LOC-1:0] lost;
    logic [2:0] owner;
    logic owner_v;
    logic [7:0] rd;
    logic ready;
    logic abort;
    logic [NUM_LOC-1:0] cmd_en;
    logic init_s1;
    logic init_s2;
    logic nv_s1;
    logic nv_s2;
  } laa_state_type;
  laa_state_type s_reg;
  laa_state_type s_next;
  laa_nv_if nv_bus();
  logic nv_clear;
  logic nv_set;

  function automatic logic one_hot_or_zero(input logic [7:0] d);
    return (d & (d - 8'h01)) == 8'h00;
  endfunction

  function automatic logic [2:0] highest(input logic [NUM_LOC-1:0] r);
    logic [2:0] h;
    h = laa_pkg::LOC_NONE;
    for (int i = 0; i < NUM_LOC; i++) begin
      if (r[i]) begin
        h = 3'(i);
      end
    end
    return h;
  endfunction

  laa_nv_bit u_nv (
    .clk(CLK),
    .reset_n(RESET_N),
    .nv_in(s_reg.nv_s2),
    .nv(nv_bus.store)
  );

  // the nonvolatile copy is cleared by RESET_N and reloads the bit from NV_STORED after every reset
  assign nv_bus.clear_req = nv_clear;
  assign nv_bus.set_req = nv_set;

  always_comb begin
    logic wr;
    logic pre;
    logic [2:0] loc;
    logic [2:0] nxt;
    logic valid;
    wr = 1'b0;
    pre = 1'b0;
    loc = LOCALITY;
    nxt = laa_pkg::LOC_NONE;
    valid = 1'b0;
    s_next = s_reg;
    s_next.init_s1 = INIT_DONE;
    s_next.init_s2 = s_reg.init_s1;
    s_next.nv_s1 = NV_STORED;
    s_next.nv_s2 = s_reg.nv_s1;
    s_next.abort = 1'b0;
    nv_clear = HASH_BEGIN;
    nv_set = RESTORE_EST && !HASH_BEGIN;
    wr = WR_STROBE && (loc < 3'(NUM_LOC));
    pre = wr && WR_DATA[laa_pkg::BIT_PREEMPT];
    if (pre) begin
      // lost flag clears alongside the preempt
      if (WR_DATA[laa_pkg::BIT_LOST]) begin
        s_next.lost[loc] = 1'b0;
      end
      // owns and request bits are ignored in a preempt write
      if (loc != 3'h0 && s_reg.owner_v && loc > s_reg.owner) begin
        s_next.lost[s_reg.owner] = 1'b1;
        s_next.owner = loc;
        s_next.req[loc] = 1'b0;
        s_next.abort = 1'b1;
      end else if (loc != 3'h0 && !s_reg.owner_v) begin
        s_next.owner = loc;
        s_next.owner_v = 1'b1;
        s_next.req[loc] = 1'b0;
      end
    end else if (wr && one_hot_or_zero(WR_DATA)) begin
      if (WR_DATA[laa_pkg::BIT_OWNS]) begin
        s_next.req[loc] = 1'b0;
        if (s_reg.owner_v && s_reg.owner == loc) begin
          s_next.owner_v = 1'b0;
        end
      end
      if (WR_DATA[laa_pkg::BIT_LOST]) begin
        s_next.lost[loc] = 1'b0;
      end
      if (WR_DATA[laa_pkg::BIT_REQ] && !(s_reg.owner_v && s_reg.owner == loc)) begin
        s_next.req[loc] = 1'b1;
      end
    end
    // grant in the cycle after release or request, far inside the timeout
    if (!s_next.owner_v) begin
      nxt = highest(s_next.req);
      if (nxt != laa_pkg::LOC_NONE) begin
        s_next.owner = nxt;
        s_next.owner_v = 1'b1;
        s_next.req[nxt] = 1'b0;
      end
    end
    for (int i = 0; i < NUM_LOC; i++) begin
      // only the owner's port executes commands
      s_next.cmd_en[i] = s_next.owner_v && s_next.owner == 3'(i);
    end
    // valid only once init is done and the stored bit is known
    valid = s_reg.init_s2 && nv_bus.known && !nv_bus.busy;
    // accept-command waits for the established-low update
    s_next.ready = CMD_READY_REQ && valid && !HASH_BEGIN && !RESTORE_EST;
    s_next.rd = 8'h00;
    if (RD_STROBE && loc < 3'(NUM_LOC)) begin
      s_next.rd[laa_pkg::BIT_VALID] = valid;
      s_next.rd[laa_pkg::BIT_OWNS] = s_reg.owner_v && s_reg.owner == loc;
      s_next.rd[laa_pkg::BIT_LOST] = s_reg.lost[loc];
      s_next.rd[laa_pkg::BIT_PREEMPT] = 1'b0;
      s_next.rd[laa_pkg::BIT_OTHER] = |(s_reg.req & ~(NUM_LOC'(1) << loc));
      s_next.rd[laa_pkg::BIT_REQ] = s_reg.req[loc];
      // never a one until the stored value is known
      s_next.rd[laa_pkg::BIT_EST] = nv_bus.known && nv_bus.value;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RD_DATA = s_reg.rd;
  assign OWNER = s_reg.owner;
  assign OWNER_VALID = s_reg.owner_v;
  assign ACCEPT_COMMAND_OK = s_reg.ready;
  assign ABORT = s_reg.abort;
  assign LOC_CMD_ENABLE = s_reg.cmd_en;
endmodule

// >>> tb/laa_monitor.sv
`timescale 1ns/10ps
module laa_monitor #(
  parameter int NUM_LOC = 5,
  parameter int TIMEOUT_A_CYC = 7500
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [2:0] LOCALITY,
  input wire logic [7:0] WR_DATA,
  input wire logic HASH_BEGIN,
  input wire logic RESTORE_EST,
  input wire logic INIT_DONE,
  input wire logic NV_STORED,
  input wire logic CMD_READY_REQ,
  input wire logic [7:0] RD_DATA,
  input wire logic [2:0] OWNER,
  input wire logic OWNER_VALID,
  input wire logic ACCEPT_COMMAND_OK,
  input wire logic ABORT,
  input wire logic [NUM_LOC-1:0] LOC_CMD_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  owner_enable_a: assert property (OWNER_VALID |-> LOC_CMD_ENABLE == NUM_LOC'(1 << OWNER))
    else $error("enable not one-hot on owner");
  idle_grant_a: assert property (WR_STROBE && !OWNER_VALID && LOCALITY < 3'h5 && WR_DATA == 8'h02
    |=> OWNER_VALID && OWNER == $past(LOCALITY)) else $error("idle request not granted");
  low_preempt_a: assert property (WR_STROBE && OWNER_VALID && WR_DATA[3] && LOCALITY <= OWNER
    |=> OWNER == $past(OWNER) && !ABORT) else $error("low preempt not ignored");
  preempt_win_a: assert property (WR_STROBE && OWNER_VALID && WR_DATA[3] && LOCALITY > OWNER
    && LOCALITY < 3'h5 |=> OWNER == $past(LOCALITY) && ABORT) else $error("preempt not taken");
  relinquish_a: assert property (WR_STROBE && OWNER_VALID && LOCALITY == OWNER && WR_DATA == 8'h20
    |=> !OWNER_VALID || OWNER != $past(OWNER)) else $error("owner kept after release");
  read_idle_a: assert property (!$past(RD_STROBE) |-> RD_DATA == 8'h00) else $error("read data not idle");
  preempt_read_a: assert property (RD_STROBE |=> RD_DATA[3] == 1'b0) else $error("preempt bit read one");
  valid_init_a: assert property (RD_DATA[7] |-> $past(INIT_DONE, 3)) else $error("valid before init");
  est_hold_a: assert property (HASH_BEGIN || RESTORE_EST |=> !ACCEPT_COMMAND_OK)
    else $error("accept raised during est update");
endmodule
bind laa_arbiter laa_monitor #(.NUM_LOC(NUM_LOC), .TIMEOUT_A_CYC(TIMEOUT_A_CYC)) laa_monitor_inst (
  .CLK(CLK), .RESET_N(RESET_N), .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .LOCALITY(LOCALITY),
  .WR_DATA(WR_DATA), .HASH_BEGIN(HASH_BEGIN), .RESTORE_EST(RESTORE_EST), .INIT_DONE(INIT_DONE),
  .NV_STORED(NV_STORED), .CMD_READY_REQ(CMD_READY_REQ), .RD_DATA(RD_DATA), .OWNER(OWNER),
  .OWNER_VALID(OWNER_VALID), .ACCEPT_COMMAND_OK(ACCEPT_COMMAND_OK), .ABORT(ABORT),
  .LOC_CMD_ENABLE(LOC_CMD_ENABLE));

// >>> tb/laa_host_model.sv
`timescale 1ns/10ps
module laa_host_model (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output logic wr_strobe,
  output logic rd_strobe,
  output logic [2:0] locality,
  output logic [7:0] wr_data
);
  initial begin
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    locality = 3'h0;
    wr_data = 8'h00;
  end
  // data inverted after release so a stale value never passes for a new one
  // never waits on an abort after a preempt
  task automatic wr(input logic [2:0] loc, input logic [7:0] d);
    @(negedge clk);
    locality = loc;
    wr_data = d;
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [2:0] loc, output logic [7:0] d);
    @(negedge clk);
    locality = loc;
    rd_strobe = 1'b1;
    @(negedge clk);
    rd_strobe = 1'b0;
    d = rd_data;
  endtask
endmodule

// >>> tb/laa_arbiter_test.sv
`timescale 1ns/10ps
module laa_arbiter_test;
  logic CLK, RESET_N, WR_STROBE, RD_STROBE, HASH_BEGIN, RESTORE_EST, INIT_DONE, NV_STORED, CMD_READY_REQ;
  logic OWNER_VALID, ACCEPT_COMMAND_OK, ABORT;
  logic [2:0] LOCALITY, OWNER;
  logic [7:0] WR_DATA, RD_DATA;
  logic [4:0] LOC_CMD_ENABLE;
  int err_total = 0;
  int compares = 0;
  laa_arbiter laa_arbiter_inst (.CLK(CLK), .RESET_N(RESET_N), .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE),
    .LOCALITY(LOCALITY), .WR_DATA(WR_DATA), .HASH_BEGIN(HASH_BEGIN), .RESTORE_EST(RESTORE_EST),
    .INIT_DONE(INIT_DONE), .NV_STORED(NV_STORED), .CMD_READY_REQ(CMD_READY_REQ), .RD_DATA(RD_DATA),
    .OWNER(OWNER), .OWNER_VALID(OWNER_VALID), .ACCEPT_COMMAND_OK(ACCEPT_COMMAND_OK), .ABORT(ABORT),
    .LOC_CMD_ENABLE(LOC_CMD_ENABLE));
  laa_host_model laa_host_model_inst (.clk(CLK), .rd_data(RD_DATA), .wr_strobe(WR_STROBE),
    .rd_strobe(RD_STROBE), .locality(LOCALITY), .wr_data(WR_DATA));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [2:0] l, input logic [7:0] d);
    laa_host_model_inst.wr(l, d);
  endtask
  task automatic rchk(input logic [2:0] l, input logic [7:0] e);
    logic [7:0] d;
    laa_host_model_inst.rd(l, d);
    chk("access_reg", e, d);
  endtask
  // nonvolatile updates take a few cycles, so poll under a bound
  task automatic poll(input logic [2:0] l, input logic [7:0] e);
    logic [7:0] d;
    for (int i = 0; i < 60; i++) begin
      laa_host_model_inst.rd(l, d);
      if (d === e) break;
    end
    chk("polled_reg", e, d);
    if (d !== e) final_report();
  endtask
  task automatic pulse(input logic restore);
    @(negedge CLK);
    if (restore) begin
      RESTORE_EST = 1'b1;
    end else begin
      HASH_BEGIN = 1'b1;
    end
    @(negedge CLK);
    HASH_BEGIN = 1'b0;
    RESTORE_EST = 1'b0;
  endtask
  task automatic t_valid();
    rchk(0, 8'h00);
    poll(0, 8'h81);
    chk("accept", 8'h01, {7'h00, ACCEPT_COMMAND_OK});
    $display("test valid done");
  endtask
  task automatic t_arb();
    w(1, 8'h02);
    chk("owner", 8'h01, {5'h00, OWNER});
    w(3, 8'h02);
    w(2, 8'h02);
    w(3, 8'h02);
    w(3, 8'h00);
    w(1, 8'h22);
    rchk(1, 8'ha5);
    rchk(3, 8'h87);
    w(1, 8'h20);
    rchk(3, 8'ha5);
    chk("cmd_enable", 8'h08, {3'h0, LOC_CMD_ENABLE});
    w(3, 8'h20);
    rchk(2, 8'ha1);
    rchk(3, 8'h81);
    $display("test arb done");
  endtask
  task automatic t_preempt();
    w(1, 8'h08);
    w(0, 8'h08);
    rchk(2, 8'ha1);
    w(4, 8'h2a);
    chk("abort", 8'h01, {7'h00, ABORT});
    // software side: poll the owns bit, then look at accept-command before sending
    poll(4, 8'ha1);
    chk("accept_after_preempt", 8'h01, {7'h00, ACCEPT_COMMAND_OK});
    rchk(2, 8'h91);
    w(4, 8'h20);
    w(1, 8'h02);
    w(2, 8'h18);
    rchk(2, 8'ha1);
    rchk(1, 8'h91);
    w(1, 8'h00);
    rchk(1, 8'h91);
    w(1, 8'h10);
    rchk(1, 8'h81);
    $display("test preempt done");
  endtask
  task automatic t_est();
    pulse(1'b0);
    chk("accept_hold", 8'h00, {7'h00, ACCEPT_COMMAND_OK});
    poll(0, 8'h80);
    // the cell keeps the cleared bit; self test reruns after the reset
    NV_STORED = 1'b0;
    INIT_DONE = 1'b0;
    RESET_N = 1'b0;
    repeat (3) @(negedge CLK);
    RESET_N = 1'b1;
    chk("owner_valid", 8'h00, {7'h00, OWNER_VALID});
    repeat (30) @(negedge CLK);
    rchk(0, 8'h00);
    INIT_DONE = 1'b1;
    poll(0, 8'h80);
    pulse(1'b1);
    poll(0, 8'h81);
    $display("test est done");
  endtask
  initial begin
    #2000000;
    err_total++;
    final_report();
  end
  initial begin
    RESET_N = 1'b0;
    HASH_BEGIN = 1'b0;
    RESTORE_EST = 1'b0;
    INIT_DONE = 1'b1;
    NV_STORED = 1'b1;
    CMD_READY_REQ = 1'b1;
    repeat (3) @(negedge CLK);
    RESET_N = 1'b1;
    t_valid();
    t_arb();
    t_preempt();
    t_est();
    final_report();
  end
endmodule
